// ===== rtl/modbus_status_regs.vh
// Purpose: Named constants for the serial status slave
// Assumes: 250 MHz core clock
// Notes:   Times kept in their own unit; cycle counts derived from them
`ifndef MODBUS_STATUS_REGS_VH
`define MODBUS_STATUS_REGS_VH
`define CLK_HZ          250000000
`define BAUD_RATE       19200
`define BIT_CYCLES      ((`CLK_HZ) / (`BAUD_RATE))
`define GAP_MS          20
`define GAP_CYCLES      (((`CLK_HZ) / 1000) * (`GAP_MS))
`define FUNC_READ_HOLD  8'h03
`define CRC_INIT        16'hffff
`define CRC_POLY        16'ha001
`define REQ_LEN         4'h8
`define EPOCH_HI_IDX    16'h0004
`define EPOCH_LO_IDX    16'h0005
`define MAX_QTY         16'h007d
`define DEF_SLAVE_ID    8'h01
`endif

// ===== rtl/uart_tx_byte.v
// Purpose: Sends one 8N1 byte on a serial line
// Assumes: Single clock; divider given as a parameter
// Notes:   Idle line is high; ready is high while no byte is in flight
`timescale 1ns/1ps
module uart_tx_byte #(
	parameter BIT_CYC = 13020
) (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       start,
	input  wire [7:0] data,
	output wire       ready,
	output wire       txd
);
	reg [9:0]  shift_ff;
	reg [3:0]  bits_ff;
	reg [15:0] cnt_ff;
	reg        txd_ff;

	// ************************************************************
	// Shift register: start bit, eight data bits lsb first, stop
	// ************************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_ff <= 10'h3ff;
			bits_ff  <= 4'h0;
			cnt_ff   <= 16'h0000;
			txd_ff   <= 1'b1;
		end else if (bits_ff == 4'h0) begin
			txd_ff <= 1'b1;
			if (start) begin
				shift_ff <= {1'b1, data, 1'b0};
				bits_ff  <= 4'ha;
				cnt_ff   <= 16'h0000;
			end
		end else if (cnt_ff == 16'h0000) begin
			txd_ff   <= shift_ff[0];
			shift_ff <= {1'b1, shift_ff[9:1]};
			cnt_ff   <= BIT_CYC[15:0] - 16'h0001;
		end else begin
			cnt_ff <= cnt_ff - 16'h0001;
			if (cnt_ff == 16'h0001 && shift_ff == 10'h3ff && bits_ff != 4'h0)
				bits_ff <= bits_ff - 4'h1;
			else if (cnt_ff == 16'h0001)
				bits_ff <= bits_ff - 4'h1;
		end
	end

	assign ready = (bits_ff == 4'h0);
	assign txd   = txd_ff;
endmodule

// ===== rtl/modbus_rtu_status_slave.v
// Purpose: Modbus RTU slave answering read holding registers
// Assumes: Serial line already converted to logic levels
// Notes:   Register map words come in on a flat port; epoch on its own port
// Function
// - Act as RTU slave; answer only frames carrying own, field-settable slave id.
// - Link runs 19200 baud, 8 data bits, 1 stop, no parity, no flow control.
// - Implement function code 3, read holding registers.
// - Each well formed request for us gets a reply with register contents.
// - Reply is id, function 3, byte count, two bytes per register, CRC.
// - Register addresses are zero-based indices into the map.
// - Registers 4 and 5 hold upper and lower halves of epoch seconds.
`timescale 1ns/1ps
`include "modbus_status_regs.vh"
module modbus_rtu_status_slave #(
	parameter NREG    = 16,
	parameter GAP_CYC = `GAP_CYCLES,
	parameter BIT_CYC = `BIT_CYCLES
) (
	input  wire             core_clk,
	input  wire             rst_n,
	input  wire [7:0]       slave_id,
	input  wire             slave_id_load,
	input  wire [NREG*16-1:0] reg_map,
	input  wire [31:0]      epoch_secs,
	input  wire             rxd,
	output wire             txd,
	output wire             busy
);
	localparam S_IDLE = 3'h0;
	localparam S_RX   = 3'h1;
	localparam S_CHK  = 3'h2;
	localparam S_TX   = 3'h3;
	localparam S_WAIT = 3'h4;

	reg        rx_s1_ff, rx_s2_ff;
	reg [7:0]  id_ff;
	reg [2:0]  state_ff;
	reg [15:0] bit_cnt_ff;
	reg [3:0]  rx_bits_ff;
	reg [7:0]  rx_sh_ff;
	reg        rx_on_ff;
	reg [31:0] gap_ff;
	reg [7:0]  buf_ff [0:7];
	reg [3:0]  nbytes_ff;
	reg        ovf_ff;
	reg [15:0] crc_ff;
	reg [15:0] start_ff, qty_ff;
	reg [8:0]  tx_idx_ff;
	reg [8:0]  tx_len_ff;
	reg        tx_go_ff;
	reg [7:0]  tx_byte_ff;

	wire       tx_ready;
	wire [15:0] nxt_crc_tx;

	// ************************************************************
	// Byte-wise CRC-16, reflected polynomial
	// ************************************************************
	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  d;
		integer i;
		reg [15:0] t;
		begin
			t = c ^ {8'h00, d};
			for (i = 0; i < 8; i = i + 1)
				t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
			crc_byte = t;
		end
	endfunction

	// Holding register word by zero-based index
	function [15:0] reg_word;
		input [15:0] idx;
		begin
			if (idx == `EPOCH_HI_IDX)
				reg_word = epoch_secs[31:16];
			else if (idx == `EPOCH_LO_IDX)
				reg_word = epoch_secs[15:0];
			else if (idx < NREG)
				reg_word = reg_map[idx[7:0]*16 +: 16];
			else
				reg_word = 16'h0000;
		end
	endfunction

	// ************************************************************
	// Input synchroniser and slave id store
	// ************************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
			id_ff    <= `DEF_SLAVE_ID;
		end else begin
			rx_s1_ff <= rxd;
			rx_s2_ff <= rx_s1_ff;
			if (slave_id_load)
				id_ff <= slave_id;
		end
	end

	// Reply byte selector
	wire [8:0]  data_pos  = tx_idx_ff - 9'h003;
	wire [15:0] word_idx  = start_ff + {8'h00, data_pos[8:1]};
	wire [15:0] word_val  = reg_word(word_idx);
	wire [8:0]  crc_pos   = tx_len_ff - 9'h002;
	reg  [7:0]  cur_byte;
	always @* begin
		if (tx_idx_ff == 9'h000)
			cur_byte = id_ff;
		else if (tx_idx_ff == 9'h001)
			cur_byte = `FUNC_READ_HOLD;
		else if (tx_idx_ff == 9'h002)
			cur_byte = {qty_ff[6:0], 1'b0};
		else if (tx_idx_ff == crc_pos)
			cur_byte = crc_ff[7:0];
		else if (tx_idx_ff > crc_pos)
			cur_byte = crc_ff[15:8];
		else
			cur_byte = data_pos[0] ? word_val[7:0] : word_val[15:8];
	end
	assign nxt_crc_tx = crc_byte(crc_ff, cur_byte);

	// ************************************************************
	// Receive, frame check and reply sequencing
	// ************************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= S_IDLE;
			bit_cnt_ff <= 16'h0000;
			rx_bits_ff <= 4'h0;
			rx_sh_ff   <= 8'h00;
			rx_on_ff   <= 1'b0;
			gap_ff     <= 32'h0;
			nbytes_ff  <= 4'h0;
			ovf_ff     <= 1'b0;
			crc_ff     <= `CRC_INIT;
			start_ff   <= 16'h0000;
			qty_ff     <= 16'h0000;
			tx_idx_ff  <= 9'h000;
			tx_len_ff  <= 9'h000;
			tx_go_ff   <= 1'b0;
			tx_byte_ff <= 8'h00;
		end else begin
			tx_go_ff <= 1'b0;
			case (state_ff)
			S_IDLE, S_RX: begin
				// Byte receiver sampling mid-bit
				if (!rx_on_ff) begin
					if (!rx_s2_ff) begin
						rx_on_ff   <= 1'b1;
						bit_cnt_ff <= BIT_CYC[16:1];
						rx_bits_ff <= 4'h0;
						state_ff   <= S_RX;
					end
				end else if (bit_cnt_ff != 16'h0000) begin
					bit_cnt_ff <= bit_cnt_ff - 16'h0001;
				end else begin
					bit_cnt_ff <= BIT_CYC[15:0] - 16'h0001;
					rx_bits_ff <= rx_bits_ff + 4'h1;
					if (rx_bits_ff >= 4'h1 && rx_bits_ff <= 4'h8)
						rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
					if (rx_bits_ff == 4'h9) begin
						rx_on_ff <= 1'b0;
						gap_ff   <= 32'h0;
						if (rx_s2_ff) begin
							if (nbytes_ff < `REQ_LEN) begin
								buf_ff[nbytes_ff[2:0]] <= rx_sh_ff;
								nbytes_ff <= nbytes_ff + 4'h1;
							end else
								ovf_ff <= 1'b1;
						end else
							ovf_ff <= 1'b1;
					end
				end
				// Silence past the gap closes the frame
				if (state_ff == S_RX && !rx_on_ff && rx_s2_ff) begin
					if (gap_ff >= GAP_CYC) begin
						state_ff <= S_CHK;
						crc_ff   <= `CRC_INIT;
						tx_idx_ff <= 9'h000;
					end else
						gap_ff <= gap_ff + 32'h1;
				end
			end
			S_CHK: begin
				// Run CRC over the six body bytes, then compare
				if (tx_idx_ff < 9'h006) begin
					crc_ff    <= crc_byte(crc_ff, buf_ff[tx_idx_ff[2:0]]);
					tx_idx_ff <= tx_idx_ff + 9'h001;
				end else begin
					start_ff  <= {buf_ff[2], buf_ff[3]};
					qty_ff    <= {buf_ff[4], buf_ff[5]};
					tx_idx_ff <= 9'h000;
					crc_ff    <= `CRC_INIT;
					tx_len_ff <= 9'h005 + {buf_ff[5], 1'b0};
					nbytes_ff <= 4'h0;
					ovf_ff    <= 1'b0;
					if (!ovf_ff && nbytes_ff == `REQ_LEN && buf_ff[0] == id_ff
						&& buf_ff[1] == `FUNC_READ_HOLD
						&& crc_ff == {buf_ff[7], buf_ff[6]}
						&& {buf_ff[4], buf_ff[5]} != 16'h0000
						&& {buf_ff[4], buf_ff[5]} <= `MAX_QTY)
						state_ff <= S_TX;
					else
						state_ff <= S_IDLE;
				end
			end
			S_TX: begin
				// Hand one byte at a time to the transmitter
				if (tx_ready && !tx_go_ff) begin
					if (tx_idx_ff == tx_len_ff)
						state_ff <= S_WAIT;
					else begin
						tx_byte_ff <= cur_byte;
						tx_go_ff   <= 1'b1;
						tx_idx_ff  <= tx_idx_ff + 9'h001;
						if (tx_idx_ff < crc_pos)
							crc_ff <= nxt_crc_tx;
					end
				end
			end
			S_WAIT: begin
				if (tx_ready && !tx_go_ff)
					state_ff <= S_IDLE;
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end

	uart_tx_byte #(
		.BIT_CYC (BIT_CYC)
	) u_tx (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (tx_go_ff),
		.data     (tx_byte_ff),
		.ready    (tx_ready),
		.txd      (txd)
	);

	assign busy = (state_ff != S_IDLE);
endmodule

// ===== verif/modbus_master_model.sv
// Purpose: Serial master that sends requests and reads reply bytes
// Assumes: 8N1 framing, BIT_CYC clocks per bit
// Notes:   Sends back to back bytes; reads sample mid-bit on falling edges
`timescale 1ns/1ps
module modbus_master_model #(
	parameter BIT_CYC = 16
) (
	input  wire  core_clk,
	input  wire  txd_line,
	output logic rxd_line
);
	// ****
	// Byte transfers
	// ****
	initial rxd_line = 1'b1;
	// One byte, lsb first, no idle between bytes
	task send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk) #1 rxd_line = f[i];
			repeat (BIT_CYC - 1) @(posedge core_clk);
		end
	endtask
	// Waits a bounded time for a start bit; ok is low on silence or bad stop
	task get(output logic [7:0] b, output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (txd_line !== 1'b0 && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		if (n < 3000) begin
			repeat (BIT_CYC / 2) @(negedge core_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(negedge core_clk);
				b[i] = txd_line;
			end
			repeat (BIT_CYC) @(negedge core_clk);
			ok = (txd_line === 1'b1);
		end
	endtask
endmodule

// ===== verif/modbus_slave_assertions.sv
// Purpose: Port checks for the serial status slave
// Assumes: Divider and gap handed in by the bind
// Notes:   Counters measure low runs on txd and idle runs on rxd
`timescale 1ns/1ps
module modbus_slave_assertions #(
	parameter GAP_CYC = 2000,
	parameter BIT_CYC = 16
) (
	input wire core_clk,
	input wire rst_n,
	input wire slave_id_load,
	input wire rxd,
	input wire txd,
	input wire busy
);
	logic [31:0] lo_ff;
	logic [31:0] idle_ff;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Run length counters
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_ff   <= 32'h0;
			idle_ff <= 32'h0;
		end else begin
			lo_ff   <= txd ? 32'h0 : lo_ff + 32'h1;
			idle_ff <= rxd ? idle_ff + 32'h1 : 32'h0;
		end
	end
	a_txd_idle_high: assert property (!busy |-> txd)
		else $error("txd low while idle");
	a_low_run_bits: assert property ($rose(txd) |-> lo_ff % BIT_CYC == 0)
		else $error("txd low run not whole bits");
	a_high_run_min: assert property ($rose(txd) && busy |-> txd [*8])
		else $error("txd high run too short");
	a_busy_on_rx: assert property (!busy && $fell(rxd) |-> ##[1:8] busy)
		else $error("busy missing on frame start");
	a_busy_holds: assert property ($rose(busy) |-> busy [*8])
		else $error("busy dropped early");
	a_reply_gap: assert property ($fell(txd) |-> idle_ff >= GAP_CYC)
		else $error("reply before idle gap");
	a_reply_busy: assert property ($fell(txd) |-> busy)
		else $error("reply outside busy");
	a_end_stop: assert property ($fell(busy) |-> txd && $past(txd))
		else $error("busy ended mid byte");
	cover property ($fell(busy));
	cover property ($fell(txd));
	cover property (slave_id_load);
endmodule
bind modbus_rtu_status_slave modbus_slave_assertions #(
	.GAP_CYC(GAP_CYC),
	.BIT_CYC(BIT_CYC)
) u_chk (
	.core_clk     (core_clk),
	.rst_n        (rst_n),
	.slave_id_load(slave_id_load),
	.rxd          (rxd),
	.txd          (txd),
	.busy         (busy)
);

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the serial status slave
// Assumes: Short divider and gap so the run stays brief
// Notes:   Expected replies built from the register contents set here
`timescale 1ns/1ps
`include "modbus_status_regs.vh"
module tb_top;
	logic         core_clk      = 1'b0;
	logic         rst_n         = 1'b0;
	logic [7:0]   slave_id      = 8'h00;
	logic         slave_id_load = 1'b0;
	logic [255:0] reg_map;
	logic [31:0]  epoch_secs    = 32'h6543_21fe;
	wire          rxd;
	wire          txd;
	wire          busy;
	int           miscompares   = 0;
	int           checks_done   = 0;
	always #2 core_clk = ~core_clk;
	modbus_rtu_status_slave #(.NREG(16), .GAP_CYC(2000), .BIT_CYC(16)) i_modbus_rtu_status_slave (
		.core_clk(core_clk), .rst_n(rst_n), .slave_id(slave_id),
		.slave_id_load(slave_id_load), .reg_map(reg_map), .epoch_secs(epoch_secs),
		.rxd(rxd), .txd(txd), .busy(busy));
	modbus_master_model #(.BIT_CYC(16)) u_master (
		.core_clk(core_clk), .txd_line(txd), .rxd_line(rxd));
	// ****
	// Helpers
	// ****
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = `CRC_INIT;
		foreach (q[k]) begin
			c = c ^ {8'h00, q[k]};
			for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
		end
		return c;
	endfunction
	function automatic logic [15:0] word(input logic [15:0] i);
		if (i == 16'h0004) return epoch_secs[31:16];
		if (i == 16'h0005) return epoch_secs[15:0];
		return (i < 16) ? reg_map[i*16 +: 16] : 16'h0000;
	endfunction
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// Sends one request and checks the reply bytes, then silence
	task xfer(input logic [7:0] id, fn, input logic [15:0] adr, qty, input bit bad, ok);
		logic [7:0]  q[$];
		logic [7:0]  e[$];
		logic [15:0] c;
		logic [15:0] w;
		logic [7:0]  b;
		bit          g;
		logic [7:0]  bc;
		q = {id, fn, adr[15:8], adr[7:0], qty[15:8], qty[7:0]};
		c = crc16(q) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[k]) u_master.send(q[k]);
		chk("busy in frame", 16'h0001, {15'h0000, busy});
		bc = {qty[6:0], 1'b0};
		e = {id, fn, bc};
		for (int i = 0; i < qty; i++) begin
			w = word(adr + i);
			e.push_back(w[15:8]);
			e.push_back(w[7:0]);
		end
		c = crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		if (!ok) e = {};
		foreach (e[k]) begin
			u_master.get(b, g);
			chk("reply byte", {8'h01, e[k]}, {7'h00, g, b});
		end
		u_master.get(b, g);
		chk("silence", 16'h0000, {15'h0000, g});
		chk("busy after", 16'h0000, {15'h0000, busy});
		repeat (2000) @(posedge core_clk);
	endtask
	// ****
	// Scenarios
	// ****
	task t_epoch();
		xfer(`DEF_SLAVE_ID, `FUNC_READ_HOLD, 16'h0004, 16'h0002, 0, 1);
	endtask
	task t_span();
		xfer(`DEF_SLAVE_ID, `FUNC_READ_HOLD, 16'h000e, 16'h0004, 0, 1);
	endtask
	task t_refuse();
		xfer(8'h5a, `FUNC_READ_HOLD, 16'h0000, 16'h0001, 0, 0);
		xfer(`DEF_SLAVE_ID, `FUNC_READ_HOLD, 16'h0000, 16'h0001, 1, 0);
		xfer(`DEF_SLAVE_ID, 8'h04, 16'h0000, 16'h0001, 0, 0);
		xfer(`DEF_SLAVE_ID, `FUNC_READ_HOLD, 16'h0000, 16'h0000, 0, 0);
		xfer(`DEF_SLAVE_ID, `FUNC_READ_HOLD, 16'h0000, 16'h007e, 0, 0);
	endtask
	task t_new_id();
		@(posedge core_clk) #1 slave_id = 8'h3c;
		slave_id_load = 1'b1;
		@(posedge core_clk) #1 slave_id_load = 1'b0;
		xfer(`DEF_SLAVE_ID, `FUNC_READ_HOLD, 16'h0001, 16'h0003, 0, 0);
		xfer(8'h3c, `FUNC_READ_HOLD, 16'h0001, 16'h0003, 0, 1);
	endtask
	task final_report();
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		for (int i = 0; i < 16; i++) reg_map[i*16 +: 16] = {12'ha00, i[3:0]};
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1'b1;
		t_epoch();
		t_span();
		t_refuse();
		t_new_id();
		final_report();
	end
	// Watchdog
	initial begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		final_report();
	end
endmodule
